/* File: rtl/eec_pkg.sv */
package eec_pkg;
	// register byte offsets
	localparam logic [11:0] CMD_OFS   = 12'h1B4;
	localparam logic [11:0] DATA_OFS  = 12'h1B8;
	localparam logic [11:0] ISTAT_OFS = 12'h1BC;
	localparam logic [11:0] IMASK_OFS = 12'h1C0;

	// command register field positions
	localparam int BUSY_BIT = 31;
	localparam int CMD_HI   = 30;
	localparam int CMD_LO   = 28;
	localparam int OVF_BIT  = 18;
	localparam int TMO_BIT  = 17;
	localparam int LDD_BIT  = 16;
	localparam int ADDR_HI  = 15;

	// command codes
	localparam logic [2:0] CMD_READ   = 3'h0;
	localparam logic [2:0] CMD_WRITE  = 3'h3;
	localparam logic [2:0] CMD_RELOAD = 3'h7;

	// loader marker in the first byte
	localparam logic [7:0] VALID_MARK = 8'hA5;

	// reset values
	localparam logic [15:0] ADDR_RST = 16'h0000;
	localparam logic [7:0]  DATA_RST = 8'h00;
	localparam logic [2:0]  CMD_RST  = 3'h0;

	// interrupt status bits
	localparam int IRQ_DONE = 0;
	localparam int IRQ_TMO  = 1;
	localparam int IRQ_LDD  = 2;

	// write response timeout
	localparam int TO_MS   = 30;
	localparam int CLK_KHZ = 200000;
	localparam int TO_CYC  = TO_MS * CLK_KHZ;

	// controller states
	typedef enum logic [1:0] {
		S_IDLE,
		S_OP,
		S_LCHK,
		S_LRUN
	} eec_st_t;
endpackage : eec_pkg

/* File: rtl/eec_ctrl.sv */
// The implementer's own choice: the strobed register port.
module eec_ctrl
	import eec_pkg::*;
#(
	parameter int TO_CYCLES = TO_CYC
) (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        soft_rst,
	input  wire logic [11:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             irq,
	output logic             ee_req,
	output logic             ee_wr,
	output logic      [15:0] ee_addr,
	output logic      [7:0]  ee_wdata,
	input  wire logic        ee_done,
	input  wire logic        ee_nack,
	input  wire logic [7:0]  ee_rdata,
	input  wire logic [15:0] size_limit,
	input  wire logic        ld_end,
	output logic      [7:0]  ld_byte,
	output logic             ld_vld,
	output logic             dev_ready
);

	// whole state of the controller
	typedef struct packed {
		eec_st_t     st;     // sequencer state
		logic        busy;   // controller busy flag
		logic [2:0]  cmd;    // command code field
		logic [15:0] addr;   // command address field
		logic [7:0]  data;   // data byte
		logic        ovf;    // loader overrun
		logic        tmo;    // timeout flag
		logic        ldd;    // load-done flag
		logic        ready;  // device ready
		logic        req;    // engine request level
		logic        rw;     // engine op is a write
		logic [15:0] eaddr;  // engine address
		logic [22:0] tcnt;   // write timeout count
		logic [7:0]  lbyte;  // byte to the parser
		logic        lvld;   // parser strobe
		logic [2:0]  istat;  // sticky events
		logic [2:0]  imask;  // event mask
		logic        irq;    // interrupt level
		logic [31:0] rdata;  // read data stage
	} eec_state_t;

	eec_state_t q, d;

	// bus decode
	logic       wr_cmd;
	logic       wr_data;
	logic       start;
	logic [2:0] new_cmd;
	logic [2:0] ev;
	logic       to_hit;

	assign wr_cmd  = reg_wr && (reg_addr == CMD_OFS);
	assign wr_data = reg_wr && (reg_addr == DATA_OFS);
	// a start only counts while idle
	assign start   = wr_cmd && reg_wdata[BUSY_BIT] && !q.busy;
	assign new_cmd = reg_wdata[CMD_HI:CMD_LO];
	// timeout limit applies to writes only
	assign to_hit  = q.rw && (q.tcnt == 23'(TO_CYCLES - 1));

	// next-state logic
	always_comb begin
		d       = q;
		ev      = 3'h0;
		d.lvld  = 1'b0;
		d.rdata = 32'h0000_0000;

		// read port, answered next cycle
		if (reg_rd) begin
			unique case (reg_addr)
				CMD_OFS: begin
					d.rdata = {q.busy, q.cmd, 9'h000, q.ovf, q.tmo, q.ldd, q.addr};
				end
				DATA_OFS: begin
					d.rdata = {24'h000000, q.data};
				end
				ISTAT_OFS: begin
					d.rdata = {29'h00000000, q.istat};
				end
				IMASK_OFS: begin
					d.rdata = {29'h00000000, q.imask};
				end
				default: begin
					d.rdata = 32'h0000_0000;
				end
			endcase
		end

		// fields frozen while busy
		if (start) begin
			d.cmd  = new_cmd;
			d.addr = reg_wdata[ADDR_HI:0];
		end
		if (wr_data && !q.busy) begin
			d.data = reg_wdata[7:0];
		end
		// write-one-to-clear flags; sets below win
		if (wr_cmd && reg_wdata[TMO_BIT]) begin
			d.tmo = 1'b0;
		end
		if (wr_cmd && reg_wdata[LDD_BIT]) begin
			d.ldd = 1'b0;
		end
		if (reg_wr && (reg_addr == IMASK_OFS)) begin
			d.imask = reg_wdata[2:0];
		end

		if (soft_rst) begin
			// digital reset reruns the loader
			d.st    = S_LCHK;
			d.busy  = 1'b1;
			d.ldd   = 1'b0;
			d.ovf   = 1'b0;
			d.ready = 1'b0;
			d.req   = 1'b1;
			d.rw    = 1'b0;
			d.eaddr = ADDR_RST;
			d.tcnt  = 23'h000000;
		end else begin
			unique case (q.st)
				S_IDLE: begin
					if (start) begin
						d.busy  = 1'b1;
						d.eaddr = reg_wdata[ADDR_HI:0];
						d.tcnt  = 23'h000000;
						unique case (new_cmd)
							CMD_READ: begin
								d.st  = S_OP;
								d.req = 1'b1;
								d.rw  = 1'b0;
							end
							CMD_WRITE: begin
								d.st  = S_OP;
								d.req = 1'b1;
								d.rw  = 1'b1;
							end
							CMD_RELOAD: begin
								d.st    = S_LCHK;
								d.req   = 1'b1;
								d.rw    = 1'b0;
								d.eaddr = ADDR_RST;
								d.ldd   = 1'b0;
								d.ovf   = 1'b0;
								d.ready = 1'b0;
							end
							default: begin
								// reserved code: refuse at once
								d.busy = 1'b0;
								d.tmo  = 1'b1;
								ev[IRQ_TMO]  = 1'b1;
								ev[IRQ_DONE] = 1'b1;
							end
						endcase
					end
				end
				S_OP: begin
					d.tcnt = q.tcnt + 23'h000001;
					if (ee_done) begin
						d.req  = 1'b0;
						d.st   = S_IDLE;
						d.busy = 1'b0;
						ev[IRQ_DONE] = 1'b1;
						if (!q.rw) begin
							d.data = ee_rdata;
						end
						if (ee_nack) begin
							d.tmo = 1'b1;
							ev[IRQ_TMO] = 1'b1;
						end
					end else if (to_hit) begin
						// no answer: drop the request
						d.req  = 1'b0;
						d.st   = S_IDLE;
						d.busy = 1'b0;
						d.tmo  = 1'b1;
						ev[IRQ_TMO]  = 1'b1;
						ev[IRQ_DONE] = 1'b1;
					end
				end
				S_LCHK: begin
					if (ee_done) begin
						if (ee_nack || (ee_rdata != VALID_MARK)) begin
							// unprogrammed or absent part
							d.req   = 1'b0;
							d.st    = S_IDLE;
							d.busy  = 1'b0;
							d.ready = 1'b1;
							d.tmo   = q.tmo | ee_nack;
							ev[IRQ_TMO]  = ee_nack;
							ev[IRQ_DONE] = 1'b1;
						end else begin
							// request stays high for next byte
							d.st    = S_LRUN;
							d.eaddr = q.eaddr + 16'h0001;
						end
					end
				end
				S_LRUN: begin
					if (ee_done) begin
						d.lbyte = ee_rdata;
						d.lvld  = 1'b1;
						if (ee_nack || ld_end || (q.eaddr >= size_limit)) begin
							d.req   = 1'b0;
							d.st    = S_IDLE;
							d.busy  = 1'b0;
							d.ready = 1'b1;
							ev[IRQ_DONE] = 1'b1;
							if (ee_nack) begin
								d.tmo = 1'b1;
								ev[IRQ_TMO] = 1'b1;
							end else if (ld_end) begin
								d.ldd = 1'b1;
								ev[IRQ_LDD] = 1'b1;
							end else begin
								d.ovf = 1'b1;
							end
						end else begin
							d.eaddr = q.eaddr + 16'h0001;
						end
					end
				end
			endcase
		end

		// sticky events, set wins over clear
		if (reg_wr && (reg_addr == ISTAT_OFS)) begin
			d.istat = q.istat & ~reg_wdata[2:0];
		end
		d.istat = d.istat | ev;
		d.irq   = |(d.istat & d.imask);
	end

	// state register; loader runs from reset
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			q       <= '0;
			q.st    <= S_LCHK;
			q.busy  <= 1'b1;
			q.req   <= 1'b1;
			q.cmd   <= CMD_RST;
			q.addr  <= ADDR_RST;
			q.data  <= DATA_RST;
			q.eaddr <= ADDR_RST;
		end else begin
			q <= d;
		end
	end

	// outputs straight from flops
	assign reg_rdata = q.rdata;
	assign irq       = q.irq;
	assign ee_req    = q.req;
	assign ee_wr     = q.rw;
	assign ee_addr   = q.eaddr;
	assign ee_wdata  = q.data;
	assign ld_byte   = q.lbyte;
	assign ld_vld    = q.lvld;
	assign dev_ready = q.ready;

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	start_read_a: assert property (
		start && !soft_rst && (new_cmd == CMD_READ)
		|=> q.busy && ee_req && !ee_wr && (ee_addr == $past(reg_wdata[15:0])))
		else $error("read start not issued");

	busy_hold_a: assert property (
		(q.st == S_OP) && !ee_done && !to_hit && !soft_rst |=> q.busy)
		else $error("busy dropped early");

	read_data_a: assert property (
		(q.st == S_OP) && !q.rw && ee_done && !soft_rst
		|=> !q.busy && (q.data == $past(ee_rdata)))
		else $error("read byte not latched");

	wr_timeout_a: assert property (
		(q.st == S_OP) && to_hit && !ee_done && !soft_rst
		|=> q.tmo && !q.busy && !ee_req)
		else $error("write timeout missed");

	soft_reset_a: assert property (
		soft_rst |=> q.busy && !dev_ready && !q.ldd && ee_req && (ee_addr == 16'h0000))
		else $error("soft reset not reloading");

	bad_code_a: assert property (
		start && !soft_rst && (new_cmd != CMD_READ) && (new_cmd != CMD_WRITE)
		&& (new_cmd != CMD_RELOAD) |=> q.tmo && !q.busy && !ee_req)
		else $error("reserved code accepted");

	start_write_a: assert property (
		start && !soft_rst && (new_cmd == CMD_WRITE) |=> ee_req && ee_wr && q.busy)
		else $error("write start not issued");

	reload_ready_a: assert property (
		start && !soft_rst && (new_cmd == CMD_RELOAD)
		|=> !dev_ready && !q.ldd && q.busy && (ee_addr == 16'h0000))
		else $error("reload not entered");

	bad_mark_a: assert property (
		(q.st == S_LCHK) && ee_done && !soft_rst && (ee_rdata != VALID_MARK)
		|=> !q.ldd && !q.busy && dev_ready)
		else $error("unprogrammed part loaded");

	overrun_a: assert property (
		(q.st == S_LRUN) && ee_done && !ee_nack && !ld_end && !soft_rst
		&& (q.eaddr >= size_limit) |=> q.ovf && !q.busy && !ee_req)
		else $error("overrun not flagged");

	// main scenarios
	read_done_c: cover property ((q.st == S_OP) && !q.rw && ee_done);
	wr_tmo_c: cover property ((q.st == S_OP) && to_hit && !ee_done);
	load_ok_c: cover property ((q.st == S_LRUN) && ee_done && ld_end && !ee_nack);
	overrun_c: cover property ($rose(q.ovf));

endmodule : eec_ctrl

/* File: tb/eec_ee_model.sv */
// behavioural serial memory behind the request/done engine link
module eec_ee_model (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        ee_req,
	input  wire logic        ee_wr,
	input  wire logic [15:0] ee_addr,
	input  wire logic [7:0]  ee_wdata,
	input  wire logic        absent,
	input  wire logic        nack,
	input  wire logic [3:0]  lat,
	input  wire logic [15:0] ld_last,
	output logic             ee_done,
	output logic             ee_nack,
	output logic      [7:0]  ee_rdata,
	output logic             ld_end
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [256]; // byte store, low address bits only
	logic [3:0] cnt_q;     // wait cycles of current request
	// answer each request after lat cycles, never while absent
	// plain always: the bench also preloads and corrupts the store
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt_q    <= 4'h0;
			ee_done  <= 1'b0;
			ee_nack  <= 1'b0;
			ld_end   <= 1'b0;
			ee_rdata <= 8'h00;
		end else begin
			ee_done  <= 1'b0;
			ee_nack  <= 1'b0;
			ld_end   <= 1'b0;
			// stale data toggles every cycle, so it holds the last answer only in every other cycle
			ee_rdata <= ~ee_rdata;
			if (ee_req && !ee_done && !absent) begin
				if (cnt_q >= lat) begin
					cnt_q    <= 4'h0;
					ee_done  <= 1'b1;
					ee_nack  <= nack;
					ld_end   <= (ee_addr == ld_last);
					ee_rdata <= mem[ee_addr[7:0]];
					if (ee_wr) mem[ee_addr[7:0]] <= ee_wdata;
				end else begin
					cnt_q <= cnt_q + 4'h1;
				end
			end
		end
	end
endmodule : eec_ee_model

/* File: tb/eeprom_command_control_bench.sv */
// self-checking bench: register port driven, memory model on engine link
module eeprom_command_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import eec_pkg::*;
	localparam int TOC = 50; // short write timeout for simulation
	logic        clock, nrst, soft_rst, reg_wr, reg_rd, absent, nack;
	logic        irq, ee_req, ee_wr, ee_done, ee_nack, ld_end, ld_vld, dev_ready;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, v;
	logic [15:0] ee_addr, size_limit, ld_last, a;
	logic [7:0]  ee_wdata, ee_rdata, ld_byte, b;
	logic [3:0]  lat;
	logic [2:0]  rsv [5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6}; // reserved codes
	int          errors, n_tests, polls, seed, n_ld; // n_ld counts parser strobes

	eec_ctrl #(.TO_CYCLES(TOC)) i_eec_ctrl (.clock(clock), .nrst(nrst), .soft_rst(soft_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq), .ee_req(ee_req), .ee_wr(ee_wr), .ee_addr(ee_addr),
		.ee_wdata(ee_wdata), .ee_done(ee_done), .ee_nack(ee_nack), .ee_rdata(ee_rdata),
		.size_limit(size_limit), .ld_end(ld_end), .ld_byte(ld_byte), .ld_vld(ld_vld),
		.dev_ready(dev_ready));
	eec_ee_model i_eec_ee_model (.clock(clock), .nrst(nrst), .ee_req(ee_req), .ee_wr(ee_wr),
		.ee_addr(ee_addr), .ee_wdata(ee_wdata), .absent(absent), .nack(nack), .lat(lat),
		.ld_last(ld_last), .ee_done(ee_done), .ee_nack(ee_nack), .ee_rdata(ee_rdata),
		.ld_end(ld_end));

	// expected start word: busy, code, address
	function automatic logic [31:0] cmdw(logic [2:0] c, logic [15:0] ad);
		return {1'b1, c, 12'h000, ad};
	endfunction : cmdw
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// one-cycle write strobe
	task automatic wr(logic [11:0] ad, logic [31:0] d);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= ad;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(logic [11:0] ad);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= ad;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	// expected command word once idle after a good load
	function automatic logic [31:0] idlew(logic [2:0] c, logic [15:0] ad);
		return {1'b0, c, 12'h001, ad};
	endfunction : idlew
	// poll busy, bounded; running out counts as a mismatch
	task automatic wait_idle;
		polls = 0;
		repeat (3000) begin
			rd(CMD_OFS);
			polls++;
			if (v[BUSY_BIT] === 1'b0) break;
		end
		chk("idle reached", v[BUSY_BIT], 0);
	endtask : wait_idle
	// look just after the edge so the fresh flop value is seen
	task automatic wait_ready;
		repeat (500) begin
			@(posedge clock);
			#1;
			if (dev_ready === 1'b1) break;
		end
		chk("ready back", dev_ready, 1);
	endtask : wait_ready
	// rerun the loader and count the bytes handed to the parser
	task automatic reload(int n_exp);
		int n0;
		n0 = n_ld;
		wr(CMD_OFS, cmdw(CMD_RELOAD, 16'h0000));
		#1 chk("ready low", dev_ready, 0);
		wait_ready;
		rd(CMD_OFS);
		chk("ld bytes", n_ld - n0, n_exp);
	endtask : reload
	task automatic close_out;
		if (errors == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : close_out

	// parser strobe counter, read at the edge that ends each pulse
	always @(posedge clock) begin
		if (ld_vld === 1'b1) begin
			n_ld <= n_ld + 1;
		end
	end

	// free-running clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// hang guard, well beyond the expected run
	initial begin
		#300000;
		errors++;
		close_out;
	end
	// main sequence
	initial begin
		{nrst, soft_rst, reg_wr, reg_rd, absent, nack} = 6'h00;
		reg_addr = 12'h000;
		reg_wdata = 32'h0;
		size_limit = 16'hFFFF;
		ld_last = 16'h0003;
		lat = 4'h2;
		seed = $urandom(32'h3C24);
		for (int i = 0; i < 256; i++) i_eec_ee_model.mem[i] = 8'(i);
		i_eec_ee_model.mem[0] = VALID_MARK;
		repeat (8) @(posedge clock);
		nrst <= 1'b1;
		rd(CMD_OFS);
		chk("busy at reset", v[BUSY_BIT], 1);
		chk("addr reset", v[15:0], ADDR_RST);
		rd(DATA_OFS);
		chk("data reset", v, {24'h0, DATA_RST});
		wait_idle;
		chk("loaded", {v[BUSY_BIT], v[LDD_BIT], dev_ready}, 3'h3);
		wr(IMASK_OFS, 32'h1);
		// random write then read back; new command only once idle
		repeat (6) begin
			// clear old events so each done interrupt is fresh
			wr(ISTAT_OFS, 32'h7);
			repeat (2) @(posedge clock);
			#1 chk("irq clear", irq, 0);
			b = 8'($urandom);
			a = 16'($urandom_range(255, 1));
			@(posedge clock);
			lat <= 4'($urandom_range(4, 1));
			wr(DATA_OFS, {24'h0, b});
			wr(CMD_OFS, cmdw(CMD_WRITE, a));
			wait_idle;
			chk("busy clear", v[BUSY_BIT], 0);
			chk("write word", v, idlew(CMD_WRITE, a));
			chk("stored", i_eec_ee_model.mem[a[7:0]], b);
			chk("irq", irq, 1);
			wr(DATA_OFS, {24'h0, ~b});
			wr(CMD_OFS, cmdw(CMD_READ, a));
			wait_idle;
			chk("read word", v, idlew(CMD_READ, a));
			rd(DATA_OFS);
			chk("read data", v, {24'h0, b});
		end
		// reserved codes flag a timeout and never run
		foreach (rsv[i]) begin
			wr(CMD_OFS, cmdw(rsv[i], 16'h0000));
			rd(CMD_OFS);
			chk("bad code", {v[BUSY_BIT], v[TMO_BIT]}, 2'h1);
			wr(CMD_OFS, 32'h1 << TMO_BIT);
			rd(CMD_OFS);
			chk("tmo clear", v[TMO_BIT], 0);
		end
		// missing acknowledge, interrupt masked
		wr(IMASK_OFS, 32'h0);
		nack <= 1'b1;
		wr(CMD_OFS, cmdw(CMD_READ, 16'h0004));
		wait_idle;
		chk("nack tmo", {v[TMO_BIT], irq}, 2'h2);
		rd(ISTAT_OFS);
		chk("istat", v[IRQ_TMO], 1);
		@(posedge clock);
		nack <= 1'b0;
		wr(CMD_OFS, 32'h1 << TMO_BIT);
		wr(ISTAT_OFS, 32'h7);
		// write with nobody answering
		absent <= 1'b1;
		wr(CMD_OFS, cmdw(CMD_WRITE, 16'h0005));
		rd(CMD_OFS);
		chk("absent busy", {v[BUSY_BIT], v[TMO_BIT]}, 2'h2);
		wait_idle;
		chk("absent tmo", {v[BUSY_BIT], v[TMO_BIT]}, 2'h1);
		// two cycles per poll, so the poll count brackets the limit
		chk("tmo wait", (polls >= TOC / 2 - 2) && (polls <= TOC / 2 + 2), 1);
		@(posedge clock);
		absent <= 1'b0;
		wr(CMD_OFS, 32'h1 << TMO_BIT);
		// reload: bad marker, good, overrun, good again
		i_eec_ee_model.mem[0] = 8'h5A;
		reload(0);
		chk("bad mark", {v[BUSY_BIT], v[LDD_BIT]}, 2'h0);
		i_eec_ee_model.mem[0] = VALID_MARK;
		reload(3);
		chk("good load", v[LDD_BIT], 1);
		chk("last byte", ld_byte, i_eec_ee_model.mem[3]);
		size_limit <= 16'h0002;
		ld_last <= 16'h0009;
		reload(2);
		chk("overrun", {v[OVF_BIT], v[LDD_BIT]}, 2'h2);
		size_limit <= 16'hFFFF;
		ld_last <= 16'h0003;
		reload(3);
		chk("ovf cleared", {v[OVF_BIT], v[LDD_BIT]}, 2'h1);
		rd(12'h000);
		chk("unmapped", v, 32'h0);
		// soft reset restarts the loader
		@(posedge clock);
		soft_rst <= 1'b1;
		@(posedge clock);
		soft_rst <= 1'b0;
		rd(CMD_OFS);
		chk("soft busy", v[BUSY_BIT], 1);
		chk("soft ready", dev_ready, 0);
		wait_idle;
		chk("soft load", {v[BUSY_BIT], v[LDD_BIT]}, 2'h1);
		close_out;
	end
endmodule : eeprom_command_control_bench
